// [bench/wsse_exec_asserts.sv]
`timescale 1ns/10ps
module wsse_exec_asserts (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_ack_o,
  input wire logic                    issue_valid_i,
  input wire logic                    issue_ready_o,
  input wire logic [31:0]             instr_i,
  input wire logic [63:0]             first_source_i,
  input wire logic [63:0]             second_source_i,
  input wire logic                    res_valid_o,
  input wire logic [63:0]             res_data_o,
  input wire logic                    exc_valid_o,
  input wire logic [6:0]              exc_code_o,
  input wire logic                    xlate_req_o,
  input wire logic [63:0]             xlate_vaddr_o,
  input wire logic                    xlate_ack_i,
  input wire wsse_pkg::wsse_xlate_type xlate_i,
  input wire logic                    mem_req_o
);
  import wsse_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        fire, alu, ok, ovf;
  logic [31:0] wa, wb, t, d;
  logic [63:0] ea, sx;
  assign fire = issue_valid_i && issue_ready_o;
  assign wa   = first_source_i[31:0];
  assign wb   = second_source_i[31:0];
  assign ea   = first_source_i + {{48{instr_i[15]}}, instr_i[15:0]};
  assign d    = wa - wb;
  assign ovf  = (wa[31] != wb[31]) && (d[31] != wa[31]);
  assign sx   = {{32{t[31]}}, t};
  assign alu  = fire && instr_i[31:26] == 6'h00 && ok;
  always_comb begin
    ok = 1'b1;
    t  = wa - wb;
    case (instr_i[5:0])
      6'h07: t = $signed(wb) >>> wa[4:0];
      6'h06: t = wb >> wa[4:0];
      6'h02: t = wb >> instr_i[10:6];
      6'h22, 6'h23: t = wa - wb;
      default: ok = 1'b0;
    endcase
    if (instr_i[5:0] != 6'h02 && instr_i[10:6] != 5'h00) ok = 1'b0;
    if (instr_i[5:0] == 6'h22 && ovf) ok = 1'b0;
  end
  sequence s_sw_issue;
    fire && instr_i[31:26] == 6'h2B;
  endsequence
  sequence s_xlate_out;
    xlate_req_o && xlate_vaddr_o == $past(ea);
  endsequence
  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_alu;
    alu |=> res_valid_o && !exc_valid_o && res_data_o == $past(sx);
  endproperty
  property p_sub_ovf;
    fire && instr_i == {6'h00, instr_i[25:11], 11'h022} && ovf |=>
      exc_valid_o && exc_code_o == 7'h01 && !res_valid_o;
  endproperty
  property p_misalign;
    s_sw_issue ##0 ea[1:0] != 2'h0 |=> exc_valid_o && exc_code_o == 7'h02 && !xlate_req_o;
  endproperty
  property p_store_xlate;
    s_sw_issue ##0 ea[1:0] == 2'h0 |=> s_xlate_out;
  endproperty
  property p_mem_after_xlate;
    $rose(mem_req_o) |-> $past(xlate_ack_i);
  endproperty
  property p_fault;
    xlate_ack_i && (xlate_i.refill || xlate_i.invalid || xlate_i.modified) |=>
      exc_valid_o && !mem_req_o;
  endproperty
  property p_busy;
    mem_req_o |-> !issue_ready_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");
  a_alu: assert property (p_alu) else $error("alu result wrong");
  a_sub_ovf: assert property (p_sub_ovf) else $error("overflow not trapped");
  a_misalign: assert property (p_misalign) else $error("misaligned store");
  a_store_xlate: assert property (p_store_xlate) else $error("bad address");
  a_mem_after_xlate: assert property (p_mem_after_xlate) else $error("early write");
  a_fault: assert property (p_fault) else $error("fault not raised");
  a_busy: assert property (p_busy) else $error("ready while storing");
endmodule // wsse_exec_asserts
bind wsse_exec wsse_exec_asserts u_chk (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .wb_cyc_i        (wb_cyc_i),
  .wb_stb_i        (wb_stb_i),
  .wb_ack_o        (wb_ack_o),
  .issue_valid_i   (issue_valid_i),
  .issue_ready_o   (issue_ready_o),
  .instr_i         (instr_i),
  .first_source_i  (first_source_i),
  .second_source_i (second_source_i),
  .res_valid_o     (res_valid_o),
  .res_data_o      (res_data_o),
  .exc_valid_o     (exc_valid_o),
  .exc_code_o      (exc_code_o),
  .xlate_req_o     (xlate_req_o),
  .xlate_vaddr_o   (xlate_vaddr_o),
  .xlate_ack_i     (xlate_ack_i),
  .xlate_i         (xlate_i),
  .mem_req_o       (mem_req_o)
);

// [bench/wsse_exec_tb.sv]
`timescale 1ns/10ps
module wsse_exec_tb;
  import wsse_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, issue_valid_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, instr_i = 0, wb_dat_o, q, r1, r2, wd, seed = 32'hB63BCA00;
  logic [63:0] first_source_i = 0, second_source_i = 0, res_data_o, xlate_vaddr_o, rdat, va;
  logic [3:0][31:0] cop_word_i = 0;
  logic wb_ack_o, irq_o, issue_ready_o, res_valid_o, exc_valid_o, done_o, xlate_req_o;
  logic xlate_ack_i, mem_req_o, mem_ack_i, rv, slow = 0;
  logic [4:0] cop_reg_o, res_dest_o;
  logic [6:0] exc_code_o, ec;
  logic [5:0] fn, opc;
  logic [7:0] ctrl;
  logic [2:0] fault = 0, lane;
  wsse_xlate_type xlate_i;
  wsse_mem_type mem_o, mo;
  int n_errors = 0, checked = 0, cyc = 0;
  logic [5:0] fns [5] = '{6'h07, 6'h02, 6'h06, 6'h22, 6'h23};
  wsse_exec dut (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_we_i         (wb_we_i),
    .wb_adr_i        (wb_adr_i),
    .wb_sel_i        (wb_sel_i),
    .wb_dat_i        (wb_dat_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .irq_o           (irq_o),
    .issue_valid_i   (issue_valid_i),
    .issue_ready_o   (issue_ready_o),
    .instr_i         (instr_i),
    .first_source_i  (first_source_i),
    .second_source_i (second_source_i),
    .cop_reg_o       (cop_reg_o),
    .cop_word_i      (cop_word_i),
    .res_valid_o     (res_valid_o),
    .res_dest_o      (res_dest_o),
    .res_data_o      (res_data_o),
    .exc_valid_o     (exc_valid_o),
    .exc_code_o      (exc_code_o),
    .done_o          (done_o),
    .xlate_req_o     (xlate_req_o),
    .xlate_vaddr_o   (xlate_vaddr_o),
    .xlate_ack_i     (xlate_ack_i),
    .xlate_i         (xlate_i),
    .mem_req_o       (mem_req_o),
    .mem_o           (mem_o),
    .mem_ack_i       (mem_ack_i)
  );
  wsse_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .fault_i(fault),
    .xlate_req_i(xlate_req_o), .xlate_vaddr_i(xlate_vaddr_o), .xlate_ack_o(xlate_ack_i),
    .xlate_o(xlate_i), .mem_req_i(mem_req_o), .mem_ack_o(mem_ack_i));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      final_report();
    end
  end
  function automatic logic [63:0] f_alu(input logic [5:0] f, input logic [31:0] a, b);
    logic [31:0] t;
    case (f)
      6'h07: t = $signed(b) >>> a[4:0];
      6'h06: t = b >> a[4:0];
      6'h02: t = b >> b[10:6];
      default: t = a - b;
    endcase
    return {{32{t[31]}}, t};
  endfunction
  function automatic logic f_ovf(input logic [31:0] a, b);
    logic [31:0] t;
    t = a - b;
    return (a[31] != b[31]) && (t[31] != a[31]);
  endfunction
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  task automatic chk_val(input logic [63:0] g, e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_exc(input logic [6:0] g, e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t exception %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic run(input logic [31:0] ins, input logic [63:0] a, b);
    @(posedge clk_i);
    issue_valid_i   <= 1;
    instr_i         <= ins;
    first_source_i  <= a;
    second_source_i <= b;
    do @(posedge clk_i); while (issue_ready_o !== 1'b1);
    issue_valid_i <= 0;
    do begin
      @(posedge clk_i);
      if (mem_req_o && mem_ack_i) mo = mem_o;
    end while (done_o !== 1'b1);
    rv   = res_valid_o;
    rdat = res_data_o;
    ec   = exc_valid_o ? exc_code_o : 7'h00;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 4; i++) begin
      r1 = rnd();
      cop_word_i[i] <= r1;
    end
    wb(1'b0, 4'h0, 32'h0);
    chk_val({32'h0, q}, 64'h0);
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h2, 32'h0);
    chk_val({32'h0, q}, 64'h0);
    $display("test registers done");
    for (int i = 0; i < 45; i++) begin
      r1 = rnd();
      r2 = rnd();
      if (i < 5) r1 = 32'h7FFFFFFF;
      if (i < 5) r2 = 32'hFFFFFFFF;
      fn = fns[i % 5];
      run({11'h000, r2[20:11], fn == 6'h02 ? r2[10:6] : 5'h00, fn}, {{32{r1[31]}}, r1},
        {{32{r2[31]}}, r2});
      if (fn == 6'h22 && f_ovf(r1, r2)) begin
        chk_exc(ec, 7'h01);
        chk_val({63'h0, rv}, 64'h0);
      end else begin
        chk_val(rv ? rdat : ~f_alu(fn, r1, r2), f_alu(fn, r1, r2));
        chk_val({59'h0, res_dest_o}, {59'h0, r2[15:11]});
      end
      if (fn == 6'h23) chk_exc(ec, 7'h00);
    end
    $display("test alu done");
    run({21'h000022, 5'h01, 6'h07}, 64'h4, 64'h10);
    chk_exc(ec, 7'h04);
    run({6'h38, 10'h022, 16'h0010}, 64'h100, 64'h0);
    chk_exc(ec, 7'h04);
    for (int k = 0; k < 4; k++) begin
      ctrl = {4'hA, 2'h0, k[1:0]};
      wb(1'b1, 4'h0, {24'h0, ctrl});
      r1 = rnd();
      r2 = rnd();
      slow <= k[0];
      opc = k[0] ? {4'hE, k[1:0]} : 6'h2B;
      wd = k[0] ? cop_word_i[k] : r2;
      run({opc, 10'h022, 16'hFFF8}, {{32{r1[31]}}, r1[31:2], 2'h0}, {{32{r2[31]}}, r2});
      chk_val({59'h0, cop_reg_o}, {59'h0, 5'h02});
      va = first_source_i + 64'hFFFFFFFFFFFFFFF8;
      lane = va[2:0] ^ {ctrl[1], 2'h0};
      chk_val({24'h0, mo.addr}, {24'h0, va[39:3], va[2] ^ ctrl[0], va[1:0]});
      chk_val(mo.data, {32'h0, wd} << (8 * lane));
      chk_val({56'h0, mo.byte_en}, {56'h0, 8'h0F << lane});
    end
    run({16'hAC22, 16'h0010}, 64'h101, 64'h5);
    chk_exc(ec, 7'h02);
    for (int j = 0; j < 3; j++) begin
      fault <= 3'b100 >> j;
      run({16'hAC22, 16'h0010}, 64'h100, 64'h5);
      chk_exc(ec, 7'h10 << j);
    end
    fault <= 0;
    run({6'h3A, 10'h022, 16'h0010}, 64'h100, 64'h0);
    chk_exc(ec, 7'h08);
    $display("test stores done");
    wb(1'b0, 4'h4, 32'h0);
    chk_val({32'h0, q}, 64'h7F);
    chk_val({63'h0, irq_o}, 64'h0);
    wb(1'b1, 4'h8, 32'h08);
    repeat (2) @(posedge clk_i);
    chk_val({63'h0, irq_o}, 64'h1);
    wb(1'b1, 4'h4, 32'h7F);
    repeat (2) @(posedge clk_i);
    chk_val({63'h0, irq_o}, 64'h0);
    $display("test interrupt done");
    final_report();
  end
endmodule // wsse_exec_tb

// [bench/wsse_far_model.sv]
`timescale 1ns/10ps
module wsse_far_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                slow_i,
  input  wire logic [2:0]          fault_i,
  input  wire logic                xlate_req_i,
  input  wire logic [63:0]         xlate_vaddr_i,
  output logic                     xlate_ack_o,
  output wsse_pkg::wsse_xlate_type xlate_o,
  input  wire logic                mem_req_i,
  output logic                     mem_ack_o
);
  import wsse_pkg::*;
  logic [3:0] wait_r;
  // fields are garbage outside the ack cycle
  assign xlate_o = xlate_ack_o ? {xlate_vaddr_i[39:0], fault_i} : {~xlate_vaddr_i[39:0], 3'h7};
  always_ff @(posedge clk_i) begin
    xlate_ack_o <= 1'b0;
    mem_ack_o   <= 1'b0;
    if (rst_i) begin
      wait_r <= 4'h0;
    end else if ((xlate_req_i && !xlate_ack_o) || (mem_req_i && !mem_ack_o)) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= (slow_i ? 4'h5 : 4'h0)) begin
        wait_r      <= 4'h0;
        xlate_ack_o <= xlate_req_i;
        mem_ack_o   <= mem_req_i;
      end
    end
  end
endmodule // wsse_far_model

// [src/wsse_cfg.svh]
`ifndef WSSE_CFG_SVH
`define WSSE_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define WSSE_XLEN        64
`define WSSE_WLEN        32
`define WSSE_PLEN        40
`define WSSE_NCOP        4

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define WSSE_OPC_HI      31
`define WSSE_OPC_LO      26
`define WSSE_RS_HI       25
`define WSSE_RS_LO       21
`define WSSE_RT_HI       20
`define WSSE_RT_LO       16
`define WSSE_RD_HI       15
`define WSSE_RD_LO       11
`define WSSE_SA_HI       10
`define WSSE_SA_LO       6
`define WSSE_FN_HI       5
`define WSSE_FN_LO       0
`define WSSE_OFF_HI      15
`define WSSE_OFF_LO      0
`define WSSE_COPN_HI     27
`define WSSE_COPN_LO     26

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define WSSE_OPC_REGFORM 6'h00
`define WSSE_OPC_SW      6'h2B
`define WSSE_OPC_SWC_TOP 4'hE
`define WSSE_FN_SHIFT_RIGHT_ARITH_VARIABLE     6'h07
`define WSSE_FN_SRL      6'h02
`define WSSE_FN_SHIFT_RIGHT_LOGICAL_VARIABLE     6'h06
`define WSSE_FN_SUB      6'h22
`define WSSE_FN_SUBTRACT_MODULO     6'h23

// ----------------------------------------------------------------
// register map (byte offsets) and fields
// ----------------------------------------------------------------
`define WSSE_ADR_CTRL    4'h0
`define WSSE_ADR_STATUS  4'h4
`define WSSE_ADR_MASK    4'h8
`define WSSE_ADR_STATE   4'hC
`define WSSE_CTRL_REV    0
`define WSSE_CTRL_BIG    1
`define WSSE_CTRL_CU_LO  4
`define WSSE_CTRL_RST    8'h00
`define WSSE_NEVT        7
`define WSSE_EVT_OVF     0
`define WSSE_EVT_ADE     1
`define WSSE_EVT_RI      2
`define WSSE_EVT_CPU     3
`define WSSE_EVT_REFILL  4
`define WSSE_EVT_INVAL   5
`define WSSE_EVT_MOD     6

`endif

// [src/wsse_exec.sv]
`timescale 1ns/10ps
// Contract
// - variable arithmetic right shift, sign-extend word
// - immediate logical right shift, sign-extend word
// - variable logical right shift, sign-extend word
// - shift sources must be sign-extended words
// - trapping subtract: overflow traps, destination kept
// - modulo subtract never traps
// - subtract sources must be sign-extended words
// - store address base plus signed offset
// - misaligned store: address error, no access
// - endian steering of address and lane
// - coprocessor supplies word for its store
// - coprocessor units 1 to 3 select store data (unit 0 store raises reserved instruction)
// - disabled coprocessor store raises unusable
// - coprocessor zero store is not defined
// - store exception set, translation and others
`include "wsse_cfg.svh"
module wsse_exec (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           irq_o,
  input  wire logic                      issue_valid_i,
  output logic                           issue_ready_o,
  input  wire logic [31:0]               instr_i,
  input  wire logic [63:0]               first_source_i,
  input  wire logic [63:0]               second_source_i,
  output logic      [4:0]                cop_reg_o,
  input  wire logic [3:0][31:0]          cop_word_i,
  output logic                           res_valid_o,
  output logic      [4:0]                res_dest_o,
  output logic      [63:0]               res_data_o,
  output logic                           exc_valid_o,
  output logic      [6:0]                exc_code_o,
  output logic                           done_o,
  output logic                           xlate_req_o,
  output logic      [63:0]               xlate_vaddr_o,
  input  wire logic                      xlate_ack_i,
  input  wire wsse_pkg::wsse_xlate_type  xlate_i,
  output logic                           mem_req_o,
  output wsse_pkg::wsse_mem_type         mem_o,
  input  wire logic                      mem_ack_i
);
  import wsse_pkg::*;

  wsse_regs_type s_r;
  wsse_regs_type s_nxt;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [4:0]  sa;
  logic [4:0]  dst;
  logic [15:0] off;
  logic [1:0]  copn;
  logic [31:0] word_b;
  logic [31:0] word_a;

  assign opc    = instr_i[`WSSE_OPC_HI:`WSSE_OPC_LO];
  assign fn     = instr_i[`WSSE_FN_HI:`WSSE_FN_LO];
  assign sa     = instr_i[`WSSE_SA_HI:`WSSE_SA_LO];
  assign dst    = instr_i[`WSSE_RD_HI:`WSSE_RD_LO];
  assign off    = instr_i[`WSSE_OFF_HI:`WSSE_OFF_LO];
  assign copn   = instr_i[`WSSE_COPN_HI:`WSSE_COPN_LO];
  assign word_a = first_source_i[31:0];
  assign word_b = second_source_i[31:0];

  // the coprocessor register address is the rt field of the issued word
  assign cop_reg_o = instr_i[`WSSE_RT_HI:`WSSE_RT_LO];

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  logic [31:0] sh_arith;
  logic [31:0] sh_imm;
  logic [31:0] sh_var;
  logic [31:0] diff;
  logic        ovf;
  logic [63:0] eff_addr;

  // result undefined unless sources are sign-extended words
  assign sh_arith = 32'($signed(word_b) >>> first_source_i[4:0]);
  assign sh_imm   = word_b >> sa;
  assign sh_var   = word_b >> first_source_i[4:0];
  assign diff     = word_a - word_b;
  assign ovf      = (word_a[31] != word_b[31]) && (diff[31] != word_a[31]);
  assign eff_addr = first_source_i + {{48{off[15]}}, off};

  // ----------------------------------------------------------------
  // bus write masking per byte lane
  // ----------------------------------------------------------------
  logic [31:0] wmask;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [`WSSE_NEVT-1:0] ev;
    logic [`WSSE_NEVT-1:0] clr;
    logic [31:0]           wdat;
    logic [31:0]           res;
    logic                  is_reg;
    logic                  is_sw;
    logic                  is_swc;
    logic                  bad;
    logic [2:0]            lane;
    ev     = '0;
    clr    = '0;
    wdat   = wb_dat_i & wmask;
    res    = '0;
    is_reg = 1'b0;
    is_sw  = 1'b0;
    is_swc = 1'b0;
    bad    = 1'b0;
    lane   = '0;
    s_nxt  = s_r;
    s_nxt.wb_ack    = 1'b0;
    s_nxt.res_valid = 1'b0;
    s_nxt.exc_valid = 1'b0;
    s_nxt.done      = 1'b0;

    // register slave: one wait cycle, unmapped reads zero
    if (wb_cyc_i && wb_stb_i && !s_r.wb_ack) begin
      s_nxt.wb_ack = 1'b1;
      s_nxt.rdata  = '0;
      case (wb_adr_i)
        `WSSE_ADR_CTRL: begin
          s_nxt.rdata = {24'h000000, s_r.ctrl};
          if (wb_we_i) begin
            s_nxt.ctrl = (s_r.ctrl & ~wmask[7:0]) | wdat[7:0];
          end
        end
        `WSSE_ADR_STATUS: begin
          s_nxt.rdata = {25'h0, s_r.status};
          if (wb_we_i) begin
            clr = wdat[`WSSE_NEVT-1:0];
          end
        end
        `WSSE_ADR_MASK: begin
          s_nxt.rdata = {25'h0, s_r.mask};
          if (wb_we_i) begin
            s_nxt.mask = (s_r.mask & ~wmask[`WSSE_NEVT-1:0]) | wdat[`WSSE_NEVT-1:0];
          end
        end
        `WSSE_ADR_STATE: begin
          s_nxt.rdata = {s_r.mem_req, 7'h00, 6'h00, s_r.state, 9'h0, s_r.last_exc};
        end
        default: begin
          s_nxt.rdata = '0;
        end
      endcase
    end

    case (s_r.state)
      ST_IDLE: begin
        if (issue_valid_i) begin
          is_reg = (opc == `WSSE_OPC_REGFORM);
          is_sw  = (opc == `WSSE_OPC_SW);
          is_swc = (opc[5:2] == `WSSE_OPC_SWC_TOP);
          if (is_reg) begin
            case (fn)
              `WSSE_FN_SHIFT_RIGHT_ARITH_VARIABLE: res = sh_arith;
              `WSSE_FN_SRL:  res = sh_imm;
              `WSSE_FN_SHIFT_RIGHT_LOGICAL_VARIABLE: res = sh_var;
              `WSSE_FN_SUB:  res = diff;
              `WSSE_FN_SUBTRACT_MODULO: res = diff;
              default:       bad = 1'b1;
            endcase
            if (fn != `WSSE_FN_SRL && sa != 5'h00) begin
              bad = 1'b1;
            end
            if (bad) begin
              ev[`WSSE_EVT_RI] = 1'b1;
            end else if (fn == `WSSE_FN_SUB && ovf) begin
              ev[`WSSE_EVT_OVF] = 1'b1;
            end else begin
              s_nxt.res_valid = 1'b1;
              s_nxt.res_dest  = dst;
              s_nxt.res_data  = {{32{res[31]}}, res};
            end
          end else if (is_swc && copn == 2'h0) begin
            ev[`WSSE_EVT_RI] = 1'b1;
          end else if (is_swc && !s_r.ctrl[`WSSE_CTRL_CU_LO + 32'(copn)]) begin
            ev[`WSSE_EVT_CPU] = 1'b1;
          end else if (is_sw || is_swc) begin
            if (eff_addr[1:0] != 2'h0) begin
              ev[`WSSE_EVT_ADE] = 1'b1;
            end else begin
              s_nxt.vaddr   = eff_addr;
              s_nxt.st_word = is_swc ? cop_word_i[copn] : word_b;
              s_nxt.state   = ST_XLATE;
            end
          end else begin
            ev[`WSSE_EVT_RI] = 1'b1;
          end
          if (ev != '0) begin
            s_nxt.exc_valid = 1'b1;
            s_nxt.last_exc  = ev;
            s_nxt.done      = 1'b1;
          end else if (s_nxt.state == ST_IDLE) begin
            s_nxt.done = 1'b1;
          end
        end
      end
      ST_XLATE: begin
        if (xlate_ack_i) begin
          ev[`WSSE_EVT_REFILL] = xlate_i.refill;
          ev[`WSSE_EVT_INVAL]  = xlate_i.invalid;
          ev[`WSSE_EVT_MOD]    = xlate_i.modified;
          if (ev != '0) begin
            s_nxt.exc_valid = 1'b1;
            s_nxt.last_exc  = ev;
            s_nxt.done      = 1'b1;
            s_nxt.state     = ST_IDLE;
          end else begin
            lane = s_r.vaddr[2:0] ^ {s_r.ctrl[`WSSE_CTRL_BIG], 2'h0};
            s_nxt.mem.addr    = {xlate_i.paddr[`WSSE_PLEN-1:3],
                                 xlate_i.paddr[2:0] ^ {s_r.ctrl[`WSSE_CTRL_REV], 2'h0}};
            s_nxt.mem.data    = {32'h00000000, s_r.st_word} << {lane, 3'h0};
            s_nxt.mem.byte_en = 8'h0F << lane;
            s_nxt.mem_req     = 1'b1;
            s_nxt.state       = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        if (mem_ack_i) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.done    = 1'b1;
          s_nxt.state   = ST_IDLE;
        end
      end
      default: begin
        s_nxt.state = ST_IDLE;
      end
    endcase

    // a new event wins over a clear in the same cycle
    s_nxt.status = (s_r.status & ~clr) | ev;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.state    <= ST_IDLE;
      s_r.ctrl     <= `WSSE_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o      = s_r.rdata;
  assign wb_ack_o      = s_r.wb_ack;
  assign irq_o         = |(s_r.status & s_r.mask);
  assign issue_ready_o = (s_r.state == ST_IDLE);
  assign res_valid_o   = s_r.res_valid;
  assign res_dest_o    = s_r.res_dest;
  assign res_data_o    = s_r.res_data;
  assign exc_valid_o   = s_r.exc_valid;
  assign exc_code_o    = s_r.last_exc;
  assign done_o        = s_r.done;
  assign xlate_req_o   = (s_r.state == ST_XLATE);
  assign xlate_vaddr_o = s_r.vaddr;
  assign mem_req_o     = s_r.mem_req;
  assign mem_o         = s_r.mem;

endmodule // wsse_exec

// [src/wsse_pkg.sv]
package wsse_pkg;
  `include "wsse_cfg.svh"

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XLATE,
    ST_MEM
  } wsse_state_type;

  typedef struct packed {
    logic [`WSSE_PLEN-1:0] paddr;
    logic                  refill;
    logic                  invalid;
    logic                  modified;
  } wsse_xlate_type;

  typedef struct packed {
    logic [`WSSE_PLEN-1:0] addr;
    logic [63:0]           data;
    logic [7:0]            byte_en;
  } wsse_mem_type;

  typedef struct packed {
    wsse_state_type        state;
    logic                  wb_ack;
    logic [31:0]           rdata;
    logic [7:0]            ctrl;
    logic [`WSSE_NEVT-1:0] status;
    logic [`WSSE_NEVT-1:0] mask;
    logic [`WSSE_NEVT-1:0] last_exc;
    logic                  res_valid;
    logic [4:0]            res_dest;
    logic [63:0]           res_data;
    logic                  exc_valid;
    logic                  done;
    logic [63:0]           vaddr;
    logic [31:0]           st_word;
    logic                  mem_req;
    wsse_mem_type          mem;
  } wsse_regs_type;
endpackage
